// ### hdl/rcd_pkg.sv
// Notes on behaviour
// - every debug input is registered on the core clock before use.
// - all read data lines of one group share a single tap value.
// - one group is the read data lines tied to one read echo clock.
// - global increment high raises every data tap by one per cycle.
// - global decrement high lowers every data tap by one per cycle.
// - select-all one steps all groups, zero steps only vector-selected groups.
// - select vector has one bit per group; a one enables that group.
// - select inputs are don't-care unless group increment or decrement is active.
// - group increment high raises selected groups' data taps by one per cycle.
// - group decrement high lowers selected groups' data taps by one per cycle.
// - per-group flag set once the echo clock's first edge is found.
// - per-group six-bit first-edge tap count, group zero in lowest bits.
// - per-group flag set once the echo clock's second edge is found.
// - per-group six-bit second-edge tap count, group zero in lowest bits.
// - per-group six-bit applied echo tap count, never beyond the tap range.
// - per-group polarity bit, one if first edge rising, zero if falling.
// - per-group done bit once core clock is centred on that echo clock.
// - per-group six-bit count of taps to apply to that group's data.
// - per-group done bit once the group's data taps reach that count.
`default_nettype none
package rcd_pkg;
	// tap counters
	localparam int unsigned RCD_TAP_W   = 6;
	localparam logic [5:0]  RCD_TAP_MAX = 6'h3f;
	localparam logic [5:0]  RCD_TAP_RST = 6'h00;
	// delay element settling time before a sample is trusted
	localparam int unsigned RCD_CLK_PERIOD_NS = 10;
	localparam int unsigned RCD_SETTLE_NS     = 100;
	localparam int unsigned RCD_SETTLE_CYC    = (RCD_SETTLE_NS + RCD_CLK_PERIOD_NS - 1) / RCD_CLK_PERIOD_NS;
	// apb register map (byte addresses)
	localparam int unsigned RCD_ADDR_W      = 8;
	localparam logic [7:0]  RCD_OFS_CTRL    = 8'h00;
	localparam logic [7:0]  RCD_OFS_STATUS  = 8'h04;
	localparam logic [7:0]  RCD_OFS_FLAGS   = 8'h08;
	localparam logic [7:0]  RCD_OFS_FIRST   = 8'h0c;
	localparam logic [7:0]  RCD_OFS_SECOND  = 8'h10;
	localparam logic [7:0]  RCD_OFS_ECHO    = 8'h14;
	localparam logic [7:0]  RCD_OFS_TARGET  = 8'h18;
	localparam logic [7:0]  RCD_OFS_DATA    = 8'h1c;
	// field positions
	localparam int unsigned RCD_CTRL_START     = 0;
	localparam int unsigned RCD_STATUS_BUSY    = 0;
	localparam int unsigned RCD_STATUS_DONE    = 1;
	localparam int unsigned RCD_STATUS_FAIL    = 8;
	localparam int unsigned RCD_STATUS_RISING  = 16;
	localparam int unsigned RCD_FLAGS_FIRST    = 0;
	localparam int unsigned RCD_FLAGS_SECOND   = 8;
	localparam int unsigned RCD_FLAGS_CENTER   = 16;
	localparam int unsigned RCD_FLAGS_DATA     = 24;
	localparam logic [31:0] RCD_PRDATA_RST     = 32'h0000_0000;
	// calibration sequencer states
	typedef enum logic [2:0] {
		RCD_IDLE   = 3'b000,
		RCD_FIRST  = 3'b001,
		RCD_SECOND = 3'b010,
		RCD_CENTER = 3'b011,
		RCD_DATA   = 3'b100,
		RCD_NEXT   = 3'b101
	} rcd_state_t;
	// sampled debug step controls
	typedef struct packed {
		logic glob_up;
		logic glob_dn;
		logic grp_up;
		logic grp_dn;
		logic sel_all;
	} rcd_dbg_t;
endpackage
`default_nettype wire

// ### hdl/rcd_debug_port.sv
`default_nettype none
module rcd_debug_port #(
	parameter int unsigned ECHO_GROUP_COUNT = 2
) (
	// clock and reset
	input  wire logic                                          CORE_CLK,
	input  wire logic                                          SRST,
	// apb slave
	input  wire logic                                          PSEL,
	input  wire logic                                          PENABLE,
	input  wire logic                                          PWRITE,
	input  wire logic [rcd_pkg::RCD_ADDR_W-1:0]                PADDR,
	input  wire logic [31:0]                                   PWDATA,
	output logic      [31:0]                                   PRDATA,
	output logic                                               PREADY,
	output logic                                               PSLVERR,
	// debug step controls
	input  wire logic                                          GLOBAL_DELAY_INCREMENT,
	input  wire logic                                          GLOBAL_DELAY_DECREMENT,
	input  wire logic                                          GROUP_ADJUST_SELECT_ALL,
	input  wire logic [ECHO_GROUP_COUNT-1:0]                   GROUP_ADJUST_SELECT_VECTOR,
	input  wire logic                                          GROUP_DELAY_INCREMENT,
	input  wire logic                                          GROUP_DELAY_DECREMENT,
	// sampled echo clock level per group from the capture flops
	input  wire logic [ECHO_GROUP_COUNT-1:0]                   ECHO_LEVEL,
	// debug results
	output logic      [ECHO_GROUP_COUNT-1:0]                   ECHO_FIRST_EDGE_FOUND,
	output logic      [rcd_pkg::RCD_TAP_W*ECHO_GROUP_COUNT-1:0] ECHO_FIRST_EDGE_TAPS,
	output logic      [ECHO_GROUP_COUNT-1:0]                   ECHO_SECOND_EDGE_FOUND,
	output logic      [rcd_pkg::RCD_TAP_W*ECHO_GROUP_COUNT-1:0] ECHO_SECOND_EDGE_TAPS,
	output logic      [rcd_pkg::RCD_TAP_W*ECHO_GROUP_COUNT-1:0] ECHO_DELAY_TAPS,
	output logic      [ECHO_GROUP_COUNT-1:0]                   ECHO_FIRST_RISING,
	output logic      [ECHO_GROUP_COUNT-1:0]                   ECHO_CENTERING_DONE,
	output logic      [rcd_pkg::RCD_TAP_W*ECHO_GROUP_COUNT-1:0] DATA_TARGET_TAPS,
	output logic      [ECHO_GROUP_COUNT-1:0]                   DATA_DELAY_DONE,
	// tap settings to the input delay elements
	output logic      [rcd_pkg::RCD_TAP_W*ECHO_GROUP_COUNT-1:0] DATA_DELAY_TAPS
);
	import rcd_pkg::*;

	localparam int unsigned G  = ECHO_GROUP_COUNT;
	localparam int unsigned GW = (G > 1) ? $clog2(G) : 1;
	localparam logic [7:0]  SETTLE_LAST = 8'(RCD_SETTLE_CYC - 1);
	localparam logic [GW-1:0] GRP_LAST  = GW'(G - 1);

	// state
	rcd_state_t          state_r, state_nxt;
	logic [GW-1:0]       grp_r;
	logic [7:0]          settle_r;
	logic                ref_r;
	logic                start_r;
	logic                done_r;
	rcd_dbg_t            dbg_r;
	logic [G-1:0]        sel_r;
	logic [G-1:0]        lvl_s1_r, lvl_s2_r;
	logic [RCD_TAP_W-1:0] data_tap_r   [G];
	logic [RCD_TAP_W-1:0] echo_tap_r   [G];
	logic [RCD_TAP_W-1:0] first_taps_r [G];
	logic [RCD_TAP_W-1:0] second_taps_r[G];
	logic [RCD_TAP_W-1:0] target_r     [G];
	logic [G-1:0]        first_r, second_r, rising_r, center_r, data_done_r, fail_r;
	logic [31:0]         prdata_r;
	logic                pready_r, pslverr_r;

	// sequencer observations for the group under calibration
	logic                 tick;
	logic                 cur_lvl;
	logic [RCD_TAP_W-1:0] cur_tap;
	logic [RCD_TAP_W:0]   edge_sum;
	logic [RCD_TAP_W-1:0] mid_tap;
	logic                 edge_seen, at_max, center_hit, data_hit, busy;
	assign busy       = state_r != RCD_IDLE;
	assign tick       = busy && (settle_r == SETTLE_LAST);
	assign cur_lvl    = lvl_s2_r[grp_r];
	assign cur_tap    = echo_tap_r[grp_r];
	assign edge_seen  = cur_lvl != ref_r;
	assign at_max     = cur_tap == RCD_TAP_MAX;
	assign edge_sum   = {1'b0, first_taps_r[grp_r]} + {1'b0, second_taps_r[grp_r]};
	assign mid_tap    = edge_sum[RCD_TAP_W:1];
	assign center_hit = cur_tap == mid_tap;
	assign data_hit   = data_tap_r[grp_r] == target_r[grp_r];

	// apb decode
	logic        setup_ph, wr_en, addr_hit;
	logic [31:0] rd_mux, rd_status, rd_flags;
	logic [RCD_TAP_W*G-1:0] first_flat, second_flat, echo_flat, target_flat, data_flat;
	assign setup_ph  = PSEL && !PENABLE;
	assign addr_hit  = (PADDR == RCD_OFS_CTRL) || (PADDR == RCD_OFS_STATUS) || (PADDR == RCD_OFS_FLAGS) ||
	                   (PADDR == RCD_OFS_FIRST) || (PADDR == RCD_OFS_SECOND) || (PADDR == RCD_OFS_ECHO) ||
	                   (PADDR == RCD_OFS_TARGET) || (PADDR == RCD_OFS_DATA);
	assign wr_en     = PSEL && PENABLE && pready_r && PWRITE && (PADDR == RCD_OFS_CTRL);
	assign rd_status = (32'(busy) << RCD_STATUS_BUSY) | (32'(done_r) << RCD_STATUS_DONE) |
	                   (32'(fail_r) << RCD_STATUS_FAIL) | (32'(rising_r) << RCD_STATUS_RISING);
	assign rd_flags  = (32'(first_r) << RCD_FLAGS_FIRST) | (32'(second_r) << RCD_FLAGS_SECOND) |
	                   (32'(center_r) << RCD_FLAGS_CENTER) | (32'(data_done_r) << RCD_FLAGS_DATA);
	assign rd_mux    = (PADDR == RCD_OFS_STATUS) ? rd_status :
	                   (PADDR == RCD_OFS_FLAGS)  ? rd_flags :
	                   (PADDR == RCD_OFS_FIRST)  ? 32'(first_flat) :
	                   (PADDR == RCD_OFS_SECOND) ? 32'(second_flat) :
	                   (PADDR == RCD_OFS_ECHO)   ? 32'(echo_flat) :
	                   (PADDR == RCD_OFS_TARGET) ? 32'(target_flat) :
	                   (PADDR == RCD_OFS_DATA)   ? 32'(data_flat) : 32'h0000_0000;

	// apb slave: read data latched in setup, answer in the first access cycle
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			prdata_r  <= RCD_PRDATA_RST;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= setup_ph;
			pslverr_r <= setup_ph && !addr_hit;
			if (setup_ph) begin
				prdata_r <= PWRITE ? 32'h0000_0000 : rd_mux;
			end
		end
	end

	// start pulse from a ctrl write, taken only while idle
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			start_r <= 1'b0;
		end else begin
			start_r <= wr_en && PWDATA[RCD_CTRL_START] && !busy && !start_r;
		end
	end

	// input sampling: debug controls registered once on the core clock
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			dbg_r <= '0;
			sel_r <= '0;
		end else begin
			dbg_r <= '{GLOBAL_DELAY_INCREMENT, GLOBAL_DELAY_DECREMENT, GROUP_DELAY_INCREMENT,
			           GROUP_DELAY_DECREMENT, GROUP_ADJUST_SELECT_ALL};
			sel_r <= GROUP_ADJUST_SELECT_VECTOR;
		end
	end

	// echo level comes from the capture flops off the core domain
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			lvl_s1_r <= '0;
			lvl_s2_r <= '0;
		end else begin
			lvl_s1_r <= ECHO_LEVEL;
			lvl_s2_r <= lvl_s1_r;
		end
	end

	// settle divider: one tick per delay step while calibrating
	always_ff @(posedge CORE_CLK) begin
		if (SRST || !busy || tick) begin
			settle_r <= 8'h00;
		end else begin
			settle_r <= settle_r + 8'h01;
		end
	end

	// sequencer next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			RCD_IDLE:   if (start_r) state_nxt = RCD_FIRST;
			RCD_FIRST:  if (tick && edge_seen) state_nxt = RCD_SECOND;
			            else if (tick && at_max) state_nxt = RCD_NEXT;
			RCD_SECOND: if (tick && edge_seen) state_nxt = RCD_CENTER;
			            else if (tick && at_max) state_nxt = RCD_NEXT;
			RCD_CENTER: if (tick && center_hit) state_nxt = RCD_DATA;
			RCD_DATA:   if (tick && data_hit) state_nxt = RCD_NEXT;
			RCD_NEXT:   state_nxt = (grp_r == GRP_LAST) ? RCD_IDLE : RCD_FIRST;
			default:    state_nxt = RCD_IDLE;
		endcase
	end

	// sequencer state, group index, edge reference
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			state_r <= RCD_IDLE;
			grp_r   <= '0;
			ref_r   <= 1'b0;
			done_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (start_r) begin
				grp_r  <= '0;
				done_r <= 1'b0;
			end else if (state_r == RCD_NEXT && grp_r != GRP_LAST) begin
				grp_r <= grp_r + GW'(1);
			end
			if (state_r == RCD_NEXT && grp_r == GRP_LAST) begin
				done_r <= 1'b1;
			end
			if (start_r || state_r == RCD_NEXT) begin
				ref_r <= start_r ? lvl_s2_r[0] : lvl_s2_r[GW'(grp_r + GW'(1))];
			end else if (tick && edge_seen) begin
				ref_r <= cur_lvl;
			end
		end
	end

	// per-group calibration results, written through the group index
	always_ff @(posedge CORE_CLK) begin
		if (SRST || start_r) begin
			first_r     <= '0;
			second_r    <= '0;
			rising_r    <= '0;
			center_r    <= '0;
			data_done_r <= '0;
			fail_r      <= '0;
			for (int i = 0; i < G; i++) begin
				echo_tap_r[i]    <= RCD_TAP_RST;
				first_taps_r[i]  <= RCD_TAP_RST;
				second_taps_r[i] <= RCD_TAP_RST;
				target_r[i]      <= RCD_TAP_RST;
			end
		end else if (tick) begin
			unique case (state_r)
				RCD_FIRST: if (edge_seen) begin
					first_r[grp_r]      <= 1'b1;
					first_taps_r[grp_r] <= cur_tap;
					rising_r[grp_r]     <= cur_lvl;
				end else if (at_max) begin
					fail_r[grp_r] <= 1'b1;
				end else begin
					// echo tap stops at the top
					echo_tap_r[grp_r] <= cur_tap + 6'h01;
				end
				RCD_SECOND: if (edge_seen) begin
					second_r[grp_r]      <= 1'b1;
					second_taps_r[grp_r] <= cur_tap;
				end else if (at_max) begin
					fail_r[grp_r] <= 1'b1;
				end else begin
					echo_tap_r[grp_r] <= cur_tap + 6'h01;
				end
				// centre echo tap, derive data tap count
				RCD_CENTER: if (center_hit) begin
					center_r[grp_r] <= 1'b1;
					target_r[grp_r] <= mid_tap;
				end else if (cur_tap > mid_tap) begin
					echo_tap_r[grp_r] <= cur_tap - 6'h01;
				end else begin
					echo_tap_r[grp_r] <= cur_tap + 6'h01;
				end
				// data taps have reached the count
				RCD_DATA: if (data_hit) begin
					data_done_r[grp_r] <= 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// data tap per group: one counter drives every data line of the group
	for (genvar g = 0; g < G; g++) begin : g_grp
		logic sel_g, up_g, dn_g, cal_own, inc_g, dec_g;
		assign sel_g   = dbg_r.sel_all || sel_r[g];
		assign up_g    = dbg_r.glob_up || (dbg_r.grp_up && sel_g);
		assign dn_g    = dbg_r.glob_dn || (dbg_r.grp_dn && sel_g);
		assign cal_own = (state_r == RCD_DATA) && (grp_r == GW'(g));
		// cancel opposing steps, saturate at the ends
		assign inc_g   = cal_own ? (tick && data_tap_r[g] < target_r[g]) :
		                           (up_g && !dn_g && data_tap_r[g] != RCD_TAP_MAX);
		assign dec_g   = cal_own ? (tick && data_tap_r[g] > target_r[g]) :
		                           (dn_g && !up_g && data_tap_r[g] != RCD_TAP_RST);
		always_ff @(posedge CORE_CLK) begin
			if (SRST) begin
				data_tap_r[g] <= RCD_TAP_RST;
			end else if (inc_g) begin
				data_tap_r[g] <= data_tap_r[g] + 6'h01;
			end else if (dec_g) begin
				data_tap_r[g] <= data_tap_r[g] - 6'h01;
			end
		end
		// group zero in the lowest bits
		assign first_flat [g*RCD_TAP_W +: RCD_TAP_W] = first_taps_r[g];
		assign second_flat[g*RCD_TAP_W +: RCD_TAP_W] = second_taps_r[g];
		assign echo_flat  [g*RCD_TAP_W +: RCD_TAP_W] = echo_tap_r[g];
		assign target_flat[g*RCD_TAP_W +: RCD_TAP_W] = target_r[g];
		assign data_flat  [g*RCD_TAP_W +: RCD_TAP_W] = data_tap_r[g];
	end

	// outputs, all straight from flops
	assign PRDATA                 = prdata_r;
	assign PREADY                 = pready_r;
	assign PSLVERR                = pslverr_r;
	assign ECHO_FIRST_EDGE_FOUND  = first_r;
	assign ECHO_FIRST_EDGE_TAPS   = first_flat;
	assign ECHO_SECOND_EDGE_FOUND = second_r;
	assign ECHO_SECOND_EDGE_TAPS  = second_flat;
	assign ECHO_DELAY_TAPS        = echo_flat;
	assign ECHO_FIRST_RISING      = rising_r;
	assign ECHO_CENTERING_DONE    = center_r;
	assign DATA_TARGET_TAPS       = target_flat;
	assign DATA_DELAY_DONE        = data_done_r;
	assign DATA_DELAY_TAPS        = data_flat;

	// checks on group zero and on the apb answer timing
	logic own0;
	assign own0 = (state_r == RCD_DATA) && (grp_r == '0);

	a_global_inc_step: assert property (@(posedge CORE_CLK) disable iff (SRST)
		dbg_r.glob_up && !dbg_r.glob_dn && !dbg_r.grp_dn && !own0 && data_tap_r[0] != RCD_TAP_MAX
		|=> data_tap_r[0] == $past(data_tap_r[0]) + 6'h01)
		else $error("global increment did not raise group 0 tap");
	a_global_dec_step: assert property (@(posedge CORE_CLK) disable iff (SRST)
		dbg_r.glob_dn && !dbg_r.glob_up && !dbg_r.grp_up && !own0 && data_tap_r[0] != RCD_TAP_RST
		|=> data_tap_r[0] == $past(data_tap_r[0]) - 6'h01)
		else $error("global decrement did not lower group 0 tap");
	a_group_sel_step: assert property (@(posedge CORE_CLK) disable iff (SRST)
		dbg_r.grp_up && !dbg_r.grp_dn && !dbg_r.glob_dn && (dbg_r.sel_all || sel_r[0]) && !own0 &&
		data_tap_r[0] != RCD_TAP_MAX |=> data_tap_r[0] == $past(data_tap_r[0]) + 6'h01)
		else $error("selected group increment missed");
	a_unselected_hold: assert property (@(posedge CORE_CLK) disable iff (SRST)
		!dbg_r.sel_all && !sel_r[0] && !dbg_r.glob_up && !dbg_r.glob_dn && !own0 |=> $stable(data_tap_r[0]))
		else $error("unselected group tap moved");
	a_opposed_hold: assert property (@(posedge CORE_CLK) disable iff (SRST)
		dbg_r.glob_up && dbg_r.glob_dn && !own0 |=> $stable(data_tap_r[0]))
		else $error("opposing steps changed tap");
	a_second_after_first: assert property (@(posedge CORE_CLK) disable iff (SRST)
		$rose(second_r[0]) |-> first_r[0] && second_taps_r[0] >= first_taps_r[0])
		else $error("second edge without first");
	a_polarity_level: assert property (@(posedge CORE_CLK) disable iff (SRST)
		$rose(first_r[0]) |-> rising_r[0] == $past(lvl_s2_r[0]))
		else $error("polarity does not match echo level");
	a_center_mid: assert property (@(posedge CORE_CLK) disable iff (SRST)
		$rose(center_r[0]) |-> echo_tap_r[0] == target_r[0] && 7'(target_r[0]) * 7'd2 <=
		7'(first_taps_r[0]) + 7'(second_taps_r[0]))
		else $error("centring not at midpoint");
	a_data_done_taps: assert property (@(posedge CORE_CLK) disable iff (SRST)
		$rose(data_done_r[0]) |-> data_tap_r[0] == target_r[0] ##1 center_r[0])
		else $error("data done before taps reached count");
	a_apb_answer: assert property (@(posedge CORE_CLK) disable iff (SRST)
		setup_ph |=> PREADY ##1 !PREADY || setup_ph)
		else $error("apb answer not in first access cycle");

	c_full_cal: cover property (@(posedge CORE_CLK) disable iff (SRST) $rose(done_r) && data_done_r[0]);
	c_fail_cal: cover property (@(posedge CORE_CLK) disable iff (SRST) $rose(fail_r[0]));
	c_group_dec: cover property (@(posedge CORE_CLK) disable iff (SRST) dbg_r.grp_dn && sel_r[0] && !dbg_r.sel_all);
	c_tap_top: cover property (@(posedge CORE_CLK) disable iff (SRST) data_tap_r[0] == RCD_TAP_MAX && dbg_r.glob_up);
endmodule
`default_nettype wire

// ### tb/rcd_echo_model.sv
`default_nettype none
module rcd_echo_model #(
	parameter logic [11:0] FIRST_TAPS  = {6'h08, 6'h0c},
	parameter logic [11:0] SECOND_TAPS = {6'h15, 6'h1e},
	parameter logic [1:0]  INVERT      = 2'h2
) (
	// clock
	input  wire logic        clk,
	// echo delay tap of each group
	input  wire logic [11:0] echo_taps,
	// echo level seen by each group's capture flop
	output logic      [1:0]  echo_level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] inside_w;
	// window between the two edges; an inverted group starts high, so its first edge falls
	// one echo per group
	for (genvar g = 0; g < 2; g++) begin : g_grp
		assign inside_w[g] = (echo_taps[6*g +: 6] >= FIRST_TAPS[6*g +: 6])
			&& (echo_taps[6*g +: 6] < SECOND_TAPS[6*g +: 6]);
	end
	// capture flop, so the level lags the tap by one cycle
	always_ff @(posedge clk) begin
		echo_level <= inside_w ^ INVERT;
	end
endmodule
`default_nettype wire

// ### tb/rcd_debug_port_tb.sv
`default_nettype none
module rcd_debug_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rcd_pkg::*;
	typedef struct packed {
		rcd_dbg_t    ctl;
		logic [1:0]  sel;
		logic [7:0]  cyc;
		logic [11:0] exp;
	} rcd_row_t;
	logic        core_clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	rcd_dbg_t    dbg;
	logic [1:0]  sel_vec, echo_level, first_found, second_found, first_rising, center_done, data_done;
	logic [11:0] first_taps, second_taps, echo_taps, target_taps, data_taps;
	logic [5:0]  exp_tap [2];
	int          err_total = 0;
	int          n_checks = 0;
	int          cyc_cnt = 0;
	// step rows: ctl bits are glob_up, glob_dn, grp_up, grp_dn, sel_all; last field is taps {group1, group0} after the row
	rcd_row_t rows [11] = '{
		{5'h10, 2'h0, 8'h03, 12'h104},
		{5'h08, 2'h0, 8'h01, 12'h0c3},
		{5'h05, 2'h0, 8'h02, 12'h145},
		{5'h04, 2'h1, 8'h02, 12'h147},
		{5'h02, 2'h2, 8'h01, 12'h107},
		{5'h01, 2'h3, 8'h02, 12'h107},
		{5'h18, 2'h0, 8'h01, 12'h107},
		{5'h12, 2'h1, 8'h01, 12'h147},
		{5'h08, 2'h0, 8'h46, 12'h000},
		{5'h10, 2'h0, 8'h46, 12'hfff},
		{5'h03, 2'h0, 8'h01, 12'hfbe}
	};
	logic [7:0]  reg_ofs [8] = '{RCD_OFS_STATUS, RCD_OFS_FLAGS, RCD_OFS_FIRST, RCD_OFS_SECOND,
		RCD_OFS_ECHO, RCD_OFS_TARGET, RCD_OFS_DATA, RCD_OFS_CTRL};
	logic [31:0] reg_exp [8] = '{32'h0001_0002, 32'h0303_0303, 32'h0000_020c, 32'h0000_055e,
		32'h0000_0395, 32'h0000_0395, 32'h0000_0395, 32'h0000_0000};

	rcd_debug_port #(.ECHO_GROUP_COUNT(2)) DUT (
		.CORE_CLK(core_clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.GLOBAL_DELAY_INCREMENT(dbg.glob_up), .GLOBAL_DELAY_DECREMENT(dbg.glob_dn),
		.GROUP_ADJUST_SELECT_ALL(dbg.sel_all), .GROUP_ADJUST_SELECT_VECTOR(sel_vec),
		.GROUP_DELAY_INCREMENT(dbg.grp_up), .GROUP_DELAY_DECREMENT(dbg.grp_dn),
		.ECHO_LEVEL(echo_level), .ECHO_FIRST_EDGE_FOUND(first_found),
		.ECHO_FIRST_EDGE_TAPS(first_taps), .ECHO_SECOND_EDGE_FOUND(second_found),
		.ECHO_SECOND_EDGE_TAPS(second_taps), .ECHO_DELAY_TAPS(echo_taps),
		.ECHO_FIRST_RISING(first_rising), .ECHO_CENTERING_DONE(center_done),
		.DATA_TARGET_TAPS(target_taps), .DATA_DELAY_DONE(data_done), .DATA_DELAY_TAPS(data_taps)
	);
	rcd_echo_model echo (.clk(core_clk), .echo_taps(echo_taps), .echo_level(echo_level));

	// clock generator
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// counts one compare, reports a mismatch
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask
	// one apb transfer, request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// a missing answer counts as a mismatch
		chk(32'(pready), 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic final_report();
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// hang guard
	always @(posedge core_clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			err_total++;
			final_report();
		end
	end
	// main sequence
	initial begin
		rcd_row_t    r;
		logic        up, dn, er;
		logic [31:0] rd;
		int          n;
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		dbg = '0;
		sel_vec = 2'h0;
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		// single pulse: sampled at the next edge, tap moves one edge later
		@(posedge core_clk);
		dbg <= 5'h10;
		@(posedge core_clk);
		dbg <= '0;
		#1 chk(32'(data_taps), 32'h0);
		@(posedge core_clk);
		#1 chk(32'(data_taps), 32'h041);
		exp_tap = '{6'h01, 6'h01};
		// table of step combinations against a per-group tap model
		for (int i = 0; i < 11; i++) begin
			r = rows[i];
			for (int c = 0; c < r.cyc; c++) begin
				@(posedge core_clk);
				dbg <= r.ctl;
				sel_vec <= r.sel;
				for (int g = 0; g < 2; g++) begin
					up = r.ctl.glob_up | (r.ctl.grp_up & (r.ctl.sel_all | r.sel[g]));
					dn = r.ctl.glob_dn | (r.ctl.grp_dn & (r.ctl.sel_all | r.sel[g]));
					if (up && !dn && exp_tap[g] != RCD_TAP_MAX)
						exp_tap[g]++;
					else if (dn && !up && exp_tap[g] != 6'h00)
						exp_tap[g]--;
				end
			end
			@(posedge core_clk);
			dbg <= '0;
			sel_vec <= 2'h0;
			repeat (2) @(posedge core_clk);
			#1 chk(32'(data_taps), 32'({exp_tap[1], exp_tap[0]}));
			chk(32'(data_taps), 32'(r.exp));
		end
		// second reset in mid-run clears every tap
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		#1 chk(32'({data_taps, echo_taps}), 32'h0);
		apb(1'b0, RCD_OFS_FLAGS, 32'h0, rd, er);
		chk(rd, 32'h0);
		// calibration of both groups, then poll for completion
		apb(1'b1, RCD_OFS_CTRL, 32'h1, rd, er);
		n = 0;
		do begin
			apb(1'b0, RCD_OFS_STATUS, 32'h0, rd, er);
			n++;
		end while (rd[RCD_STATUS_DONE] !== 1'b1 && n < 2000);
		// a poll that runs out counts as a mismatch
		chk(32'(rd[RCD_STATUS_DONE]), 32'h1);
		// flags are hardware-owned, a write must not touch them
		apb(1'b1, RCD_OFS_FLAGS, 32'h0, rd, er);
		chk(32'(er), 32'h0);
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, reg_ofs[i], 32'h0, rd, er);
			chk(rd, reg_exp[i]);
			chk(32'(er), 32'h0);
		end
		#1 chk(32'({first_found, second_found, center_done, data_done, first_rising}), 32'h3fd);
		chk(32'({first_taps, second_taps}), 32'h0020_c55e);
		chk(32'({echo_taps, target_taps}), 32'h0039_5395);
		chk(32'(data_taps), 32'h395);
		// unmapped offset answers with an error and zero data
		apb(1'b0, 8'h40, 32'h0, rd, er);
		chk(rd, 32'h0);
		chk(32'(er), 32'h1);
		final_report();
	end
endmodule
`default_nettype wire
